// ---- inc/qdac_pkg.sv ----
// Shared constants and carrier types for the quad converter serial command block.
`default_nettype none

package qdac_pkg;

    // ------------------------------------------------------------------
    // Frame geometry
    // ------------------------------------------------------------------
    localparam int FRAME_BITS = 24;
    localparam int DATA_W     = 16;
    localparam int CHANNELS   = 4;
    localparam int RANGE_W    = 3;
    localparam int CFG_W      = 4;
    localparam int COUNT_W    = 5;

    // One serial command as it arrives, most significant bit first.
    typedef struct packed {
        logic              read_not_write;
        logic              zero;
        logic [2:0]        register_select;
        logic [2:0]        channel_address;
        logic [DATA_W-1:0] data;
    } qdac_frame_t;

    // ------------------------------------------------------------------
    // Register select and control function codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        QDAC_REG_CODE    = 3'b000,
        QDAC_REG_RANGE   = 3'b001,
        QDAC_REG_POWER   = 3'b010,
        QDAC_REG_CONTROL = 3'b011
    } qdac_reg_sel_t;

    typedef enum logic [2:0] {
        QDAC_FN_NOP    = 3'b000,
        QDAC_FN_CONFIG = 3'b001,
        QDAC_FN_CLEAR  = 3'b100,
        QDAC_FN_LOAD   = 3'b101
    } qdac_ctrl_fn_t;

    localparam logic [2:0] ADDR_ALL_CHANNELS = 3'b100;

    // ------------------------------------------------------------------
    // Configuration bits of the control register
    // ------------------------------------------------------------------
    localparam int CFG_OUTPUT_DRIVER_OFF  = 0;
    localparam int CFG_CLEAR_LEVEL_SELECT = 1;
    localparam int CFG_CLAMP_ENABLE       = 2;
    localparam int CFG_THERMAL_SHUTDOWN   = 3;
    localparam logic [CFG_W-1:0] CFG_RESET = 4'h4;

    // ------------------------------------------------------------------
    // Output range codes and power control layout
    // ------------------------------------------------------------------
    localparam logic [RANGE_W-1:0] RANGE_RESET       = 3'h0;
    localparam logic [RANGE_W-1:0] RANGE_BIPOLAR_MIN = 3'h3;
    localparam logic [RANGE_W-1:0] RANGE_BIPOLAR_MAX = 3'h5;
    localparam int PWR_UP_LSB      = 0;
    localparam int PWR_REF_UP      = 4;
    localparam int PWR_THERMAL     = 5;
    localparam int PWR_OC_LSB      = 7;

    // ------------------------------------------------------------------
    // Code values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] CODE_ZERO = 16'h0000;
    localparam logic [DATA_W-1:0] CODE_MID  = 16'h8000;
    localparam logic [DATA_W-1:0] CODE_FULL = 16'hffff;

endpackage

`default_nettype wire

// ---- design/qdac_serial_rx.sv ----
// Link-clock side: frame shifter, word hand-off toggle and readback shifter.
`default_nettype none

module qdac_serial_rx
(
    input  wire logic                                 reset_in,
    input  wire logic                                 serial_clock_in,
    input  wire logic                                 frame_sync_n_in,
    input  wire logic                                 serial_data_in,
    input  wire logic [qdac_pkg::FRAME_BITS-1:0]      readback_in,
    output var  qdac_pkg::qdac_frame_t                frame_out,
    output var  logic                                 frame_toggle_out,
    output var  logic                                 serial_data_out
);

    localparam logic [qdac_pkg::COUNT_W-1:0] LAST_BIT =
        qdac_pkg::COUNT_W'(qdac_pkg::FRAME_BITS - 1);
    localparam logic [qdac_pkg::COUNT_W-1:0] FULL_COUNT =
        qdac_pkg::COUNT_W'(qdac_pkg::FRAME_BITS);

    // ------------------------------------------------------------------
    // State: per-frame part is wiped by the frame signal itself.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [qdac_pkg::FRAME_BITS-1:0] shift;
        logic [qdac_pkg::FRAME_BITS-1:0] out_shift;
        logic [qdac_pkg::COUNT_W-1:0]    count;
    } qdac_rx_frame_t;

    typedef struct packed {
        qdac_pkg::qdac_frame_t word;
        logic                  toggle;
    } qdac_rx_hold_t;

    qdac_rx_frame_t frm;
    qdac_rx_hold_t  hold;
    qdac_rx_frame_t next_frm;
    qdac_rx_hold_t  next_hold;
    logic           frame_clear;

    // The link clock stops between frames, so a partial frame is dropped by sync going high.
    assign frame_clear = reset_in | frame_sync_n_in;

    // ------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------
    always_comb
    begin
        next_frm  = frm;
        next_hold = hold;
        next_frm.shift = {frm.shift[qdac_pkg::FRAME_BITS-2:0], serial_data_in};
        if (frm.count != FULL_COUNT)
        begin
            next_frm.count = frm.count + 1'b1;
        end
        // Only the 24th edge hands a word over; later edges of an overlong frame are ignored.
        if (frm.count == LAST_BIT)
        begin
            next_hold.word   = qdac_pkg::qdac_frame_t'(next_frm.shift);
            next_hold.toggle = ~hold.toggle;
        end
        // The readback word is loaded on the first edge of the following frame.
        if (frm.count == '0)
        begin
            next_frm.out_shift = readback_in;
        end
        else
        begin
            next_frm.out_shift = {frm.out_shift[qdac_pkg::FRAME_BITS-2:0], 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    always_ff @(posedge serial_clock_in or posedge frame_clear)
    begin
        if (frame_clear)
            frm <= '0;
        else
            frm <= next_frm;
    end

    always_ff @(posedge serial_clock_in or posedge reset_in)
    begin
        if (reset_in)
            hold <= '0;
        else
            hold <= next_hold;
    end

    assign frame_out        = hold.word;
    assign frame_toggle_out = hold.toggle;
    assign serial_data_out  = frm.out_shift[qdac_pkg::FRAME_BITS-1];

endmodule

`default_nettype wire

// ---- design/qdac_core.sv ----
// Command decoder and register set of the quad converter serial interface.
//
// Behaviour
// - Each frame is 24 bits; each full frame is one register access.
// - Top frame bit zero means write, one means read.
// - Select 000 code, 001 range, 010 power, 011 control register.
// - Address 0 to 3 picks one channel, 100 picks all four.
// - Code width follows variant; unused low data bits are ignored.
// - Range access uses data bits 2 to 0 on addressed channels.
// - Range codes 000 to 101 name six output spans; others undefined.
// - Control address picks no-op, configuration, clear or load.
// - No-op changes nothing and ignores its data.
// - Clear forces all channel codes to the clear code immediately.
// - Load copies pending inputs into channel codes, updating outputs.
// - Configuration bit 0 set turns the serial output driver off.
// - Bit 2 set clamps overcurrent; cleared powers the channel down.
// - Bit 3 enables thermal shutdown; reset value is disabled.
// - Bit 1 picks clear code: zero volts, or midscale/negative full scale.
// - Pending codes, ranges, power-up and configuration bits can be written and read back; alert bits are read-only.
// - Enabled overtemperature powers down all channels and sets a flag.
`default_nettype none

module qdac_core
#(
    parameter int DATA_BITS = 16
)
(
    input  wire logic                                          clk_in,
    input  wire logic                                          reset_in,
    input  wire logic                                          serial_clock_in,
    input  wire logic                                          frame_sync_n_in,
    input  wire logic                                          serial_data_in_in,
    input  wire logic [qdac_pkg::CHANNELS-1:0]                 overcurrent_in,
    input  wire logic                                          overtemp_in,
    input  wire logic                                          twos_complement_in,
    output var  logic                                          serial_data_out_out,
    output var  logic                                          serial_data_out_oe_out,
    output var  logic [qdac_pkg::CHANNELS-1:0][qdac_pkg::DATA_W-1:0]  channel_code_out,
    output var  logic [qdac_pkg::CHANNELS-1:0][qdac_pkg::RANGE_W-1:0] output_range_out,
    output var  logic [qdac_pkg::CHANNELS-1:0]                 power_up_out,
    output var  logic                                          ref_power_up_out,
    output var  logic                                          clamp_enable_out,
    output var  logic                                          thermal_alert_out
);

    // ------------------------------------------------------------------
    // Variant width
    // ------------------------------------------------------------------
    // Low bits below the variant's width never reach a register.
    localparam logic [qdac_pkg::DATA_W-1:0] CODE_MASK =
        qdac_pkg::CODE_FULL << (qdac_pkg::DATA_W - DATA_BITS);

    // ------------------------------------------------------------------
    // State of the clock-domain side
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                                            tgl_meta;
        logic                                            tgl_sync;
        logic                                            tgl_seen;
        logic [qdac_pkg::CHANNELS-1:0]                   oc_meta;
        logic [qdac_pkg::CHANNELS-1:0]                   oc_sync;
        logic                                            ot_meta;
        logic                                            ot_sync;
        logic                                            twos_meta;
        logic                                            twos_sync;
        logic [qdac_pkg::CHANNELS-1:0][qdac_pkg::DATA_W-1:0]  pending;
        logic [qdac_pkg::CHANNELS-1:0][qdac_pkg::DATA_W-1:0]  code;
        logic [qdac_pkg::CHANNELS-1:0][qdac_pkg::RANGE_W-1:0] range;
        logic [qdac_pkg::CFG_W-1:0]                      config_bits;
        logic [qdac_pkg::CHANNELS-1:0]                   power_up;
        logic                                            ref_up;
        logic                                            thermal_alert;
        logic [qdac_pkg::CHANNELS-1:0]                   oc_alert;
        logic [qdac_pkg::FRAME_BITS-1:0]                 readback;
        logic                                            sdo_oe;
    } qdac_state_t;

    qdac_state_t           st;
    qdac_state_t           next_st;
    qdac_pkg::qdac_frame_t rx_frame;
    logic                  rx_toggle;
    logic                  rx_sdo;
    logic                  frame_new;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // True when a channel address selects the given channel.
    function automatic logic channel_hit(input logic [2:0] addr, input int ch);
        return (addr == 3'(ch)) || (addr == qdac_pkg::ADDR_ALL_CHANNELS);
    endfunction

    function automatic logic is_bipolar(input logic [qdac_pkg::RANGE_W-1:0] rng);
        return (rng >= qdac_pkg::RANGE_BIPOLAR_MIN) && (rng <= qdac_pkg::RANGE_BIPOLAR_MAX);
    endfunction

    // Clear code for one channel; undefined range codes are treated as unipolar.
    function automatic logic [qdac_pkg::DATA_W-1:0] clear_code(
        input logic [qdac_pkg::RANGE_W-1:0] rng,
        input logic                         level_sel,
        input logic                         twos);
        logic bipolar;
        bipolar = is_bipolar(rng);
        if (!level_sel)
        begin
            // Zero volts: a bipolar range in offset binary puts it at midscale; every other case is code zero.
            return (bipolar && !twos) ? qdac_pkg::CODE_MID : qdac_pkg::CODE_ZERO;
        end
        else if (!bipolar)
        begin
            return qdac_pkg::CODE_MID;
        end
        else
        begin
            return twos ? qdac_pkg::CODE_MID : qdac_pkg::CODE_ZERO;
        end
    endfunction

    // ------------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------------
    // The readback word is held steady from a few clocks after a frame until
    // the next frame's first edge, so the link side may take it whole.
    qdac_serial_rx u_rx
    (
        .reset_in         (reset_in),
        .serial_clock_in  (serial_clock_in),
        .frame_sync_n_in  (frame_sync_n_in),
        .serial_data_in   (serial_data_in_in),
        .readback_in      (st.readback),
        .frame_out        (rx_frame),
        .frame_toggle_out (rx_toggle),
        .serial_data_out  (rx_sdo)
    );

    // A changed toggle marks one new complete frame; its word is already stable.
    assign frame_new = st.tgl_sync ^ st.tgl_seen;

    // ------------------------------------------------------------------
    // Next state: synchronisers, frame decode, then hardware events.
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [qdac_pkg::DATA_W-1:0] rd_data;
        logic [1:0]                  rd_ch;
        rd_data = '0;
        rd_ch   = rx_frame.channel_address[1:0];
        next_st = st;

        // Pins from outside the clock domain pass two flip-flops first.
        next_st.tgl_meta  = rx_toggle;
        next_st.tgl_sync  = st.tgl_meta;
        next_st.tgl_seen  = st.tgl_sync;
        next_st.oc_meta   = overcurrent_in;
        next_st.oc_sync   = st.oc_meta;
        next_st.ot_meta   = overtemp_in;
        next_st.ot_sync   = st.ot_meta;
        next_st.twos_meta = twos_complement_in;
        next_st.twos_sync = st.twos_meta;

        if (frame_new && !rx_frame.read_not_write)
        begin
            unique case (qdac_pkg::qdac_reg_sel_t'(rx_frame.register_select))
                qdac_pkg::QDAC_REG_CODE:
                begin
                    for (int ch = 0; ch < qdac_pkg::CHANNELS; ch++)
                    begin
                        if (channel_hit(rx_frame.channel_address, ch))
                        begin
                            next_st.pending[ch] = rx_frame.data & CODE_MASK;
                        end
                    end
                end
                qdac_pkg::QDAC_REG_RANGE:
                begin
                    for (int ch = 0; ch < qdac_pkg::CHANNELS; ch++)
                    begin
                        if (channel_hit(rx_frame.channel_address, ch))
                        begin
                            next_st.range[ch] = rx_frame.data[qdac_pkg::RANGE_W-1:0];
                        end
                    end
                end
                qdac_pkg::QDAC_REG_POWER:
                begin
                    // Alert bits are read-only; a write only moves the power-up bits.
                    next_st.power_up =
                        rx_frame.data[qdac_pkg::PWR_UP_LSB +: qdac_pkg::CHANNELS];
                    next_st.ref_up = rx_frame.data[qdac_pkg::PWR_REF_UP];
                end
                qdac_pkg::QDAC_REG_CONTROL:
                begin
                    unique case (qdac_pkg::qdac_ctrl_fn_t'(rx_frame.channel_address))
                        qdac_pkg::QDAC_FN_NOP:
                        begin
                            next_st.readback = st.readback;
                        end
                        qdac_pkg::QDAC_FN_CONFIG:
                        begin
                            next_st.config_bits = rx_frame.data[qdac_pkg::CFG_W-1:0];
                        end
                        qdac_pkg::QDAC_FN_CLEAR:
                        begin
                            for (int ch = 0; ch < qdac_pkg::CHANNELS; ch++)
                            begin
                                next_st.code[ch] = clear_code(st.range[ch],
                                    st.config_bits[qdac_pkg::CFG_CLEAR_LEVEL_SELECT],
                                    st.twos_sync) & CODE_MASK;
                            end
                        end
                        qdac_pkg::QDAC_FN_LOAD:
                        begin
                            next_st.code = st.pending;
                        end
                        default:
                        begin
                            // Unassigned control functions are ignored like a no-op.
                            next_st.readback = st.readback;
                        end
                    endcase
                end
                default:
                begin
                    // Unassigned register selects leave every register alone.
                    next_st.readback = st.readback;
                end
            endcase
        end
        else if (frame_new)
        begin
            // Reading channel address 100 returns channel A.
            unique case (qdac_pkg::qdac_reg_sel_t'(rx_frame.register_select))
                qdac_pkg::QDAC_REG_CODE:
                begin
                    rd_data = st.pending[rd_ch];
                end
                qdac_pkg::QDAC_REG_RANGE:
                begin
                    rd_data[qdac_pkg::RANGE_W-1:0] = st.range[rd_ch];
                end
                qdac_pkg::QDAC_REG_POWER:
                begin
                    rd_data[qdac_pkg::PWR_UP_LSB +: qdac_pkg::CHANNELS] = st.power_up;
                    rd_data[qdac_pkg::PWR_REF_UP]  = st.ref_up;
                    rd_data[qdac_pkg::PWR_THERMAL] = st.thermal_alert;
                    rd_data[qdac_pkg::PWR_OC_LSB +: qdac_pkg::CHANNELS] = st.oc_alert;
                    // Reading the alerts clears them; a fresh event below sets them again.
                    next_st.thermal_alert = 1'b0;
                    next_st.oc_alert      = '0;
                end
                qdac_pkg::QDAC_REG_CONTROL:
                begin
                    rd_data[qdac_pkg::CFG_W-1:0] = st.config_bits;
                end
                default:
                begin
                    rd_data = '0;
                end
            endcase
            // The answer echoes the request header above the register contents.
            next_st.readback = {rx_frame.read_not_write, rx_frame.zero,
                                rx_frame.register_select, rx_frame.channel_address,
                                rd_data};
        end

        // Hardware events come last so that they win over a same-cycle clear or write.
        for (int ch = 0; ch < qdac_pkg::CHANNELS; ch++)
        begin
            if (st.oc_sync[ch])
            begin
                next_st.oc_alert[ch] = 1'b1;
                if (!next_st.config_bits[qdac_pkg::CFG_CLAMP_ENABLE])
                begin
                    next_st.power_up[ch] = 1'b0;
                end
            end
        end
        if (st.ot_sync && next_st.config_bits[qdac_pkg::CFG_THERMAL_SHUTDOWN])
        begin
            next_st.thermal_alert = 1'b1;
            next_st.power_up      = '0;
        end

        // The driver enable follows the configuration bit in the same clock.
        next_st.sdo_oe = ~next_st.config_bits[qdac_pkg::CFG_OUTPUT_DRIVER_OFF];
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            st             <= '0;
            st.config_bits <= qdac_pkg::CFG_RESET;
            st.sdo_oe      <= 1'b1;
            st.range       <= {qdac_pkg::CHANNELS{qdac_pkg::RANGE_RESET}};
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, each straight from a flip-flop.
    // ------------------------------------------------------------------
    assign serial_data_out_out    = rx_sdo;
    assign serial_data_out_oe_out = st.sdo_oe;
    assign channel_code_out       = st.code;
    assign output_range_out       = st.range;
    assign power_up_out           = st.power_up;
    assign ref_power_up_out       = st.ref_up;
    assign clamp_enable_out       = st.config_bits[qdac_pkg::CFG_CLAMP_ENABLE];
    assign thermal_alert_out      = st.thermal_alert;

endmodule

`default_nettype wire

// ---- test/qdac_core_chk.sv ----
// Port assertions for the quad converter command block.
`default_nettype none
module qdac_core_chk
#(
    parameter int DATA_BITS = 16
)
(
    input wire logic             clk_in,
    input wire logic             reset_in,
    input wire logic             frame_sync_n_in,
    input wire logic             serial_data_out_oe_out,
    input wire logic [3:0][15:0] channel_code_out,
    input wire logic [3:0][2:0]  output_range_out,
    input wire logic [3:0]       power_up_out,
    input wire logic             clamp_enable_out,
    input wire logic             thermal_alert_out
);
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    // Registers move only after a frame has closed, since decode waits for all bits.
    a_reset_values: assert property ($fell(reset_in) |-> clamp_enable_out
        && serial_data_out_oe_out && power_up_out == '0) else $error("bad reset value");
    a_codes_quiet: assert property (!frame_sync_n_in [*3] |=> $stable(channel_code_out))
        else $error("code moved in frame");
    a_oe_steady: assert property (!frame_sync_n_in |=> $stable(serial_data_out_oe_out))
        else $error("enable moved in frame");
    // Updates land a few clocks after the last edge, with sync already high.
    a_clamp_steady: assert property ($changed(clamp_enable_out)
        |-> $past(frame_sync_n_in, 1)) else $error("clamp moved in frame");
    a_low_bits: assert property (((channel_code_out[0] | channel_code_out[1]
        | channel_code_out[2] | channel_code_out[3]) << DATA_BITS) == 16'h0000)
        else $error("low bits");
    a_thermal_down: assert property ($rose(thermal_alert_out)
        |-> ##[0:1] power_up_out == '0) else $error("still powered");
    a_alert_sticky: assert property (thermal_alert_out && !frame_sync_n_in
        |=> thermal_alert_out) else $error("alert dropped");
    a_range_alone: assert property ($changed(output_range_out)
        |-> $stable(channel_code_out)) else $error("range and code moved");
endmodule
bind qdac_core qdac_core_chk #(.DATA_BITS(DATA_BITS)) chk_u (.clk_in, .reset_in, .frame_sync_n_in,
    .serial_data_out_oe_out, .channel_code_out, .output_range_out, .power_up_out, .clamp_enable_out,
    .thermal_alert_out);
`default_nettype wire

// ---- test/qdac_host.sv ----
// Host serial port model that shifts command frames into the block.
`default_nettype none
module qdac_host
(
    output var  logic serial_clock_out,
    output var  logic frame_sync_n_out,
    output var  logic serial_data_out,
    input  wire logic serial_data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {serial_clock_out, frame_sync_n_out, serial_data_out} = 3'b010;
    // Clock idles low between frames; released data flips so stale bits never look driven.
    task automatic send(input logic [23:0] w, input int n, output logic [23:0] rb);
        frame_sync_n_out = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            serial_data_out = w[23 - i];
            #40 serial_clock_out = 1'b1;
            #40 serial_clock_out = 1'b0;
            rb[23 - i] = serial_data_in;
        end
        #40 frame_sync_n_out = 1'b1;
        serial_data_out = ~serial_data_out;
        #600;
    endtask
endmodule
`default_nettype wire

// ---- test/quad_dac_serial_register_map_tb_top.sv ----
// Self-checking bench for the quad converter serial command block.
`default_nettype none
module quad_dac_serial_register_map_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0, reset_in = 1'b1, overtemp_in = 1'b0, twos_complement_in, rd = 1'b0;
    logic serial_clock_in, frame_sync_n_in, serial_data_in_in, serial_data_out_out;
    logic serial_data_out_oe_out, clamp_enable_out, thermal_alert_out, ref_power_up_out;
    logic [3:0] overcurrent_in = 4'h0, power_up_out, cfg = 4'h4;
    logic [3:0][15:0] channel_code_out;
    logic [3:0][2:0] output_range_out;
    logic [15:0] pend [4] = '{default: 0}, code [4] = '{default: 0};
    logic [2:0] rng [4] = '{default: 0};
    logic [23:0] w, rb, xrb;
    int n_fail, tests_run, seed = 32'hfec1e257, a, r;
    qdac_core #(.DATA_BITS(14)) dut_u (.clk_in, .reset_in, .serial_clock_in, .frame_sync_n_in,
        .serial_data_in_in, .overcurrent_in, .overtemp_in, .twos_complement_in,
        .serial_data_out_out, .serial_data_out_oe_out, .channel_code_out, .output_range_out,
        .power_up_out, .ref_power_up_out, .clamp_enable_out, .thermal_alert_out);
    qdac_host host_u (.serial_clock_out(serial_clock_in), .frame_sync_n_out(frame_sync_n_in),
        .serial_data_out(serial_data_in_in), .serial_data_in(serial_data_out_out));
    initial forever #25 clk_in = ~clk_in;
    initial #1ms print_verdict(1);
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        tests_run++;
        if (got !== exp) n_fail++;
        if (got !== exp) $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    // Reference model of one whole write frame; 14-bit codes drop the two low bits.
    task automatic apply(input logic [23:0] f);
        for (int c = 0; c < 4; c++)
        begin
            if (f[23:19] == 5'h0 && f[18:16] inside {c, 4})
                pend[c] = f[15:0] & 16'hfffc;
            if (f[23:19] == 5'h1 && f[18:16] inside {c, 4}) rng[c] = f[2:0];
            if (f[23:16] == 8'h19) cfg = f[3:0];
            if (f[23:16] == 8'h1c) code[c] = {cfg[1] ^
                (rng[c] inside {[3:5]} && !twos_complement_in), 15'h0};
            if (f[23:16] == 8'h1d) code[c] = pend[c];
        end
    endtask
    task automatic print_verdict(input int extra);
        n_fail += extra;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Random frames, every tenth cut short, then an overtemperature run.
    initial
    begin
        twos_complement_in = 1'($random(seed));
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 60; i++)
        begin
            r = $random(seed);
            w = {!r[29] && r[31:30] == 2'b0, 1'b0, r[28] ? 3'h1 : {1'b0, r[29], r[29]},
                r[29] ? {r[26], 1'b0, r[25]} : 3'(r[26:24] % 5), 16'($random(seed))};
            w[0] = w[0] & !w[20];
            host_u.send(w, (i % 10 == 9) ? 23 : 24, rb);
            if (i % 10 != 9)
            begin
                if (rd) chk(rb, xrb);
                a = (w[18:16] == 3'h4) ? 0 : int'(w[18:16]);
                xrb = {w[23:16], w[19] ? 16'(rng[a]) : pend[a]};
                rd = w[23];
                apply(w);
            end
            chk({channel_code_out, serial_data_out_oe_out, clamp_enable_out,
                output_range_out}, {code[3], code[2], code[1], code[0], !cfg[0], cfg[2],
                rng[3], rng[2], rng[1], rng[0]});
            $display("test %0d done", i);
        end
        host_u.send(24'h190009, 24, rb);
        chk(serial_data_out_oe_out, 1'b0);
        host_u.send(24'h10001f, 24, rb);
        @(posedge clk_in) {overtemp_in, overcurrent_in} <= 5'h12;
        repeat (5) @(posedge clk_in);
        host_u.send(24'h180000, 24, rb);
        chk({thermal_alert_out, ref_power_up_out, power_up_out}, 6'h30);
        // Driver back on, then read the power and control registers back.
        host_u.send(24'h190008, 24, rb);
        host_u.send(24'h900000, 24, rb);
        host_u.send(24'h980000, 24, rb);
        chk(rb, 24'h900130);
        host_u.send(24'h180000, 24, rb);
        chk(rb, 24'h980008);
        $display("alarm test done");
        print_verdict(0);
    end
endmodule
`default_nettype wire
